// [verilog/sra_defines.svh]
/*
 * Constants of the serial readout block: widths, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the package only; the modules see it through the unit.
 */
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define SRA_RESULT_BITS 18
`define SRA_STATUS_BITS 6
`define SRA_CFG_TURBO 1
`define SRA_CFG_HIGHZ 2
`define SRA_CFG_SPAN 3
`define SRA_CFG_STATUS_EN 4
`define SRA_ST_OV 5
`define SRA_ST_SPAN 4
`define SRA_ST_HIGHZ 3
`define SRA_ST_TURBO 2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SRA_OV_IDLE 1'b1
`define SRA_CLK_PERIOD_NS 100
`define SRA_CONV_TIME_NS 300
`define SRA_CONV_CYCLES ((`SRA_CONV_TIME_NS + `SRA_CLK_PERIOD_NS - 1) / `SRA_CLK_PERIOD_NS)

`endif

// [verilog/sra_pkg.sv]
/*
 * Types shared by the serial readout block.
 * Assumes the defines header is on the include path.
 */
`include "sra_defines.svh"

package sra_pkg;

    // Pin levels after synchronisation.
    typedef struct packed {
        logic convert_start;
        logic serial_in;
        logic sck;
        logic ovn;
    } sra_pins_type;

    // Conversion engine states.
    typedef enum logic [0:0] {
        SRA_CV_ACQ = 1'b0,
        SRA_CV_CONV = 1'b1
    } sra_cv_type;

    // Readout engine states.
    typedef enum logic [1:0] {
        SRA_RD_OFF = 2'b00,
        SRA_RD_ARMED = 2'b01,
        SRA_RD_SHIFT = 2'b10
    } sra_rd_type;

endpackage

// [verilog/sra_sync.sv]
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous to SYS_CLK.
 */
`timescale 1ns/1ns
`default_nettype none

module sra_sync
    import sra_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sra_pins_type pins_in,
    output sra_pins_type pins_out
);

    sra_pins_type meta_ff;
    sra_pins_type sync_ff;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= '{convert_start: 1'b0, serial_in: 1'b1, sck: 1'b0, ovn: 1'b1};
            sync_ff <= '{convert_start: 1'b0, serial_in: 1'b1, sck: 1'b0, ovn: 1'b1};
        end
        else
        begin
            meta_ff <= pins_in;
            sync_ff <= meta_ff;
        end
    end

    assign pins_out = sync_ff;

endmodule

`default_nettype wire

// [verilog/sra_fifo.sv]
/*
 * Small first-in first-out buffer built from flip-flops.
 * Assumes both sides run on the same clock; in_ready comes from a flop.
 */
`timescale 1ns/1ns
`default_nettype none

module sra_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
        begin
            $error("sra_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
        end
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic room_ff, nxt_room;
    logic push, pop;

    // Wraps an index at the buffer depth.
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
        bump = (idx == AW'(DEPTH - 1)) ? '0 : idx + AW'(1);
    endfunction

    // Next pointers and fill level.
    always_comb
    begin
        push = in_valid & room_ff;
        pop = out_ready & (cnt_ff != '0);
        nxt_wr = push ? bump(wr_ff) : wr_ff;
        nxt_rd = pop ? bump(rd_ff) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        nxt_room = (nxt_cnt != (AW+1)'(DEPTH));
    end

    // Registers the pointers, level and storage.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            room_ff <= 1'b1;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            room_ff <= nxt_room;
            if (push)
            begin
                mem_ff[wr_ff] <= in_data;
            end
        end
    end

    assign in_ready = room_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];

endmodule

`default_nettype wire

// [verilog/sra_readout.sv]
/*
 * Conversion start and serial result readout of an 18-bit converter
 * in chip-select framed modes, with the optional six-bit status word.
 * Assumes SYS_CLK runs well above the serial clock, which is sampled;
 * the analog core delivers results on RESULT_VALID/RESULT_READY.
 */
// Notes on behaviour
// - With status enabled, six status bits follow the last result bit.
// - Overvoltage status bit is low on overvoltage, refreshed every conversion.
// - Output floats once the sixth status bit has been shifted out.
// - A new conversion start is accepted even mid status word.
// - Status order: overvoltage, span, high-Z, turbo, two reserved zeros.
// - Config turbo bit 1 replaces busy indication with turbo readout.
// - Turbo start edge begins conversion and offers the previous result.
// - Without busy, MSB appears at select fall, next bits on falling clocks.
// - Without busy, output floats at last falling edge or on select release.
// - Output bit stays stable across the rising serial clock edge and changes after a falling one.
// - Start edge with serial_in high starts conversion and floats output.
// - Busy mode keeps output floating until conversion completes.
// - Busy mode drives output low at completion, then shifts MSB first.
// - Busy mode floats after the optional 19th falling edge (25th with status) or release.
// - After each conversion the core powers down until the next start.
// - 4-wire turbo: serial_in low presents MSB; floats at end or release.
// - serial_in is latched at each start edge: high selects framed mode.
// - Busy indication is on if either select line is low at completion.
// - Status bits are appended only when enabled; enable resets cleared.
// - Turbo is never combined with daisy-chain operation.
`timescale 1ns/1ns
`default_nettype none

module sra_readout
    import sra_pkg::*;
#(
    parameter int CONV_CYCLES = `SRA_CONV_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CONVERT_START,
    input wire logic SERIAL_IN,
    input wire logic SERIAL_CLK,
    input wire logic OVERVOLTAGE_N,
    input wire logic [7:0] CONFIG_REG,
    input wire logic RESULT_VALID,
    output logic RESULT_READY,
    input wire logic [`SRA_RESULT_BITS-1:0] RESULT_DATA,
    output logic CORE_START,
    output logic CORE_POWER_DOWN,
    output logic SERIAL_OUT_O,
    output logic SERIAL_OUT_OE
);

    localparam int RB = `SRA_RESULT_BITS;
    localparam int SB = `SRA_STATUS_BITS;
    localparam int WB = RB + SB;

    initial
    begin
        if (CONV_CYCLES < 1 || CONV_CYCLES > 4096)
        begin
            $error("sra_readout CONV_CYCLES out of range");
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    sra_pins_type pins_raw, pins, prev_ff;
    logic cnv_rise, sel, prev_sel, sel_fall, sel_release, sck_fall;
    logic [RB:0] fifo_data;
    logic fifo_valid, fifo_take;

    assign pins_raw = '{convert_start: CONVERT_START, serial_in: SERIAL_IN, sck: SERIAL_CLK,
                        ovn: OVERVOLTAGE_N};

    sra_sync u_sync (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .pins_in(pins_raw),
        .pins_out(pins)
    );

    // Results wait here so a slow drain by the conversion engine loses none.
    sra_fifo #(
        .WIDTH(RB + 1),
        .DEPTH(2)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .in_valid(RESULT_VALID),
        .in_ready(RESULT_READY),
        .in_data({pins.ovn, RESULT_DATA}),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    // Select is active whenever either select line is low.
    always_comb
    begin
        sel = ~(pins.convert_start & pins.serial_in);
        prev_sel = ~(prev_ff.convert_start & prev_ff.serial_in);
        cnv_rise = pins.convert_start & ~prev_ff.convert_start;
        sel_fall = sel & ~prev_sel;
        sel_release = ~sel & prev_sel;
        sck_fall = ~pins.sck & prev_ff.sck;
    end

    // ----------------------------------------------------------------
    // Conversion engine
    // ----------------------------------------------------------------
    sra_cv_type cv_ff, nxt_cv;
    logic [12:0] cnt_ff, nxt_cnt;
    logic framed_ff, nxt_framed;
    logic start_ok, conv_done;
    logic [WB-1:0] last_ff, nxt_last;
    logic cstart_ff, nxt_cstart;
    logic pdown_ff, nxt_pdown;

    // Builds the status word for a result; reserved bits read zero.
    function automatic logic [SB-1:0] status_of(input logic ovn, input logic [7:0] cfg);
        logic [SB-1:0] s;
        s = '0;
        s[`SRA_ST_OV] = ovn;
        s[`SRA_ST_SPAN] = cfg[`SRA_CFG_SPAN];
        s[`SRA_ST_HIGHZ] = cfg[`SRA_CFG_HIGHZ];
        s[`SRA_ST_TURBO] = cfg[`SRA_CFG_TURBO];
        status_of = s;
    endfunction

    // Starts, times and completes one conversion.
    always_comb
    begin
        start_ok = cnv_rise & pins.serial_in & (cv_ff == SRA_CV_ACQ);
        conv_done = (cv_ff == SRA_CV_CONV) & (cnt_ff == '0) & fifo_valid;
        fifo_take = conv_done;
        nxt_cv = cv_ff;
        nxt_cnt = cnt_ff;
        nxt_framed = framed_ff;
        nxt_last = last_ff;
        nxt_cstart = 1'b0;
        nxt_pdown = pdown_ff;
        if (cnv_rise)
        begin
            nxt_framed = pins.serial_in;
        end
        case (cv_ff)
            SRA_CV_ACQ:
            begin
                if (start_ok)
                begin
                    nxt_cv = SRA_CV_CONV;
                    nxt_cnt = 13'(CONV_CYCLES - 1);
                    nxt_cstart = 1'b1;
                    nxt_pdown = 1'b0;
                end
            end
            SRA_CV_CONV:
            begin
                // Runs on regardless of convert_start once started.
                if (cnt_ff != '0)
                begin
                    nxt_cnt = cnt_ff - 13'h0001;
                end
                if (conv_done)
                begin
                    nxt_cv = SRA_CV_ACQ;
                    nxt_pdown = 1'b1;
                    nxt_last = {fifo_data[RB-1:0], status_of(fifo_data[RB], CONFIG_REG)};
                end
            end
            default:
            begin
                nxt_cv = SRA_CV_ACQ;
            end
        endcase
    end

    // Registers the conversion engine.
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            prev_ff <= '{convert_start: 1'b0, serial_in: 1'b1, sck: 1'b0, ovn: 1'b1};
            cv_ff <= SRA_CV_ACQ;
            cnt_ff <= '0;
            framed_ff <= 1'b1;
            last_ff <= {{RB{1'b0}}, `SRA_OV_IDLE, {(SB-1){1'b0}}};
            cstart_ff <= 1'b0;
            pdown_ff <= 1'b1;
        end
        else
        begin
            prev_ff <= pins;
            cv_ff <= nxt_cv;
            cnt_ff <= nxt_cnt;
            framed_ff <= nxt_framed;
            last_ff <= nxt_last;
            cstart_ff <= nxt_cstart;
            pdown_ff <= nxt_pdown;
        end
    end

    // ----------------------------------------------------------------
    // Readout engine
    // ----------------------------------------------------------------
    sra_rd_type rd_ff, nxt_rd;
    logic [WB-1:0] sh_ff, nxt_sh;
    logic [4:0] left_ff, nxt_left;
    logic out_ff, nxt_out;
    logic oe_ff, nxt_oe;
    logic turbo, stat_en, busy;
    logic [4:0] frame_len;

    // Shifts the word out on falling serial clock edges.
    always_comb
    begin
        turbo = CONFIG_REG[`SRA_CFG_TURBO] & framed_ff;
        stat_en = CONFIG_REG[`SRA_CFG_STATUS_EN];
        busy = framed_ff & ~turbo & sel;
        frame_len = stat_en ? 5'(WB) : 5'(RB);
        nxt_rd = rd_ff;
        nxt_sh = sh_ff;
        nxt_left = left_ff;
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        case (rd_ff)
            SRA_RD_OFF:
            begin
            end
            SRA_RD_ARMED:
            begin
                if (sel_fall)
                begin
                    nxt_rd = SRA_RD_SHIFT;
                    nxt_out = sh_ff[WB-1];
                    nxt_oe = 1'b1;
                    nxt_sh = {sh_ff[WB-2:0], 1'b0};
                    nxt_left = frame_len - 5'h01;
                end
            end
            SRA_RD_SHIFT:
            begin
                if (sel_release)
                begin
                    nxt_rd = SRA_RD_OFF;
                    nxt_oe = 1'b0;
                end
                else if (sck_fall)
                begin
                    if (left_ff == '0)
                    begin
                        nxt_rd = SRA_RD_OFF;
                        nxt_oe = 1'b0;
                    end
                    else
                    begin
                        nxt_out = sh_ff[WB-1];
                        nxt_sh = {sh_ff[WB-2:0], 1'b0};
                        nxt_left = left_ff - 5'h01;
                    end
                end
            end
            default:
            begin
                nxt_rd = SRA_RD_OFF;
                nxt_oe = 1'b0;
            end
        endcase
        // A start always floats the output, even mid status word.
        if (start_ok)
        begin
            nxt_oe = 1'b0;
            nxt_rd = SRA_RD_OFF;
            if (turbo)
            begin
                nxt_rd = SRA_RD_ARMED;
                nxt_sh = last_ff;
            end
        end
        else if (conv_done && framed_ff && !turbo)
        begin
            nxt_sh = nxt_last;
            if (busy)
            begin
                nxt_rd = SRA_RD_SHIFT;
                nxt_out = 1'b0;
                nxt_oe = 1'b1;
                nxt_left = frame_len;
            end
            else
            begin
                nxt_rd = SRA_RD_ARMED;
            end
        end
    end

    // Registers the readout engine.
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_ff <= SRA_RD_OFF;
            sh_ff <= '0;
            left_ff <= '0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else
        begin
            rd_ff <= nxt_rd;
            sh_ff <= nxt_sh;
            left_ff <= nxt_left;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    assign CORE_START = cstart_ff;
    assign CORE_POWER_DOWN = pdown_ff;
    assign SERIAL_OUT_O = out_ff;
    assign SERIAL_OUT_OE = oe_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_last_fall;
        (rd_ff == SRA_RD_SHIFT) && sck_fall && (left_ff == '0) && !sel_release && !start_ok;
    endsequence

    sequence s_busy_end;
        conv_done && framed_ff && !turbo && busy && !start_ok;
    endsequence

    a_release_float: assert property ((rd_ff == SRA_RD_SHIFT) && sel_release && !conv_done
        |=> !SERIAL_OUT_OE) else $error("output not floated on release");
    a_frame_end: assert property (s_last_fall |=> !SERIAL_OUT_OE && rd_ff == SRA_RD_OFF)
        else $error("output not floated after last bit");
    a_start_float: assert property (start_ok |=> !SERIAL_OUT_OE && cv_ff == SRA_CV_CONV)
        else $error("start did not float output");
    a_busy_low: assert property (s_busy_end |=> SERIAL_OUT_OE && !SERIAL_OUT_O
        && left_ff == frame_len) else $error("busy bit not driven");
    a_msb_first: assert property ((rd_ff == SRA_RD_ARMED) && sel_fall && !start_ok
        |=> SERIAL_OUT_OE && SERIAL_OUT_O == $past(sh_ff[WB-1])) else $error("MSB wrong");
    a_turbo_prev: assert property (start_ok && turbo |=> rd_ff == SRA_RD_ARMED
        && sh_ff == $past(last_ff)) else $error("turbo did not offer previous result");
    a_power_down: assert property (conv_done |=> CORE_POWER_DOWN && cv_ff == SRA_CV_ACQ)
        else $error("core not powered down");
    a_conv_runs: assert property ((cv_ff == SRA_CV_CONV) && (cnt_ff != '0)
        |=> cv_ff == SRA_CV_CONV) else $error("conversion cut short");
    a_status_layout: assert property (conv_done |=> last_ff[1:0] == 2'b00
        && last_ff[`SRA_ST_OV] == $past(fifo_data[RB])) else $error("status word wrong");
    a_bit_stable: assert property ((rd_ff == SRA_RD_SHIFT) && !sck_fall && !sel_release
        && !start_ok && !conv_done |=> $stable(SERIAL_OUT_O)) else $error("bit moved");

endmodule

`default_nettype wire

// [dv/sra_host.sv]
/*
 * Host serial master model: select lines, serial clock, bit capture.
 * Assumes its tasks are entered just after a SYS_CLK rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module sra_host (
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic convert_start,
    output logic serial_in,
    output logic sck
);
    logic last = 1'b0;
    logic line;

    // A released output reads back as the inverse of its last level.
    always @(sdo_o or sdo_oe)
        if (sdo_oe)
            last = sdo_o;
    assign line = sdo_oe ? sdo_o : ~last;

    // Waits the quiet time after a start, then selects the device.
    task automatic select(input bit four);
        #400;
        if (four)
            serial_in = 1'b0;
        else
            convert_start = 1'b0;
    endtask

    // Clock idles low outside frames; each bit is taken on a rise.
    // The bench clock is far below full-rate turbo speed; only throughput suffers.
    task automatic shift(input int n, output logic [24:0] bits);
        bits = '0;
        repeat (n)
        begin
            #400;
            sck = 1'b1;
            bits = {bits[23:0], line};
            #400;
            sck = 1'b0;
        end
    endtask

    // Idle levels: framed mode chosen, clock low.
    initial
    begin
        convert_start = 1'b0;
        serial_in = 1'b1;
        sck = 1'b0;
    end
endmodule
`default_nettype wire

// [dv/tb_sar_adc_serial_readout.sv]
/*
 * Self-checking bench of the serial readout block: host model, core model.
 * Assumes the defines, package and design files are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_sar_adc_serial_readout;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ovn = 1'b1;
    logic [7:0] cfg = 8'h00;
    logic vld = 1'b0;
    logic [17:0] dat = 18'h0_0000;
    logic rdy, cst, pd, so, oe, convert_start, serial_in, sck;
    int failures = 0;
    int n_checks = 0;
    logic [18:0] q[$];
    logic [18:0] cur = '0;
    logic [18:0] prev = '0;
    logic [24:0] got;

    sra_readout #(.CONV_CYCLES(6)) dut_u (.SYS_CLK(clk), .SYS_RST(rst), .CONVERT_START(convert_start),
        .SERIAL_IN(serial_in), .SERIAL_CLK(sck), .OVERVOLTAGE_N(ovn), .CONFIG_REG(cfg),
        .RESULT_VALID(vld), .RESULT_READY(rdy), .RESULT_DATA(dat), .CORE_START(cst),
        .CORE_POWER_DOWN(pd), .SERIAL_OUT_O(so), .SERIAL_OUT_OE(oe));
    sra_host host_u (.sdo_o(so), .sdo_oe(oe), .convert_start(convert_start), .serial_in(serial_in), .sck(sck));

    // System clock of 100 ns period.
    always #50 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Core result push with its overvoltage level; holds until taken.
    task automatic push();
        logic [18:0] w;
        w = {1'($urandom), 18'($urandom)};
        ovn = w[18];
        tick(4);
        vld = 1'b1;
        dat = w[17:0];
        q.push_back(w);
        while (rdy !== 1'b1)
            tick(1);
        tick(1);
        vld = 1'b0;
    endtask

    // One conversion; busy lowers the select early and holds it low.
    task automatic conv(input bit busy);
        int k;
        if (convert_start)
        begin
            host_u.convert_start = 1'b0;
            tick(4);
        end
        host_u.convert_start = 1'b1;
        k = 0;
        if (busy)
        begin
            tick(2);
            host_u.convert_start = 1'b0;
        end
        while (cst !== 1'b1 && k < 20)
        begin
            tick(1);
            k++;
        end
        chk({cst, oe}, 2'b10);
        tick(1);
        k = 0;
        while (pd !== 1'b1 && k < 40)
        begin
            chk(oe, 0);
            tick(1);
            k++;
        end
        chk({pd, cst}, 2'b10);
        prev = cur;
        cur = q.pop_front();
        if (busy)
            chk({oe, so}, 2'b10);
    endtask

    // Shifts n bits of a len-bit frame and checks the float at its end.
    task automatic rd(input int n, input int len, input logic [24:0] e);
        host_u.shift(n, got);
        chk(got, e >> (len - n));
        tick(4);
        if (n == len)
            chk(oe, 0);
    endtask

    // Core model answers every start with a fresh result.
    always
    begin
        @(posedge clk);
        #2;
        if (cst === 1'b1)
            push();
    end

    // Watchdog against a hang.
    initial
    begin
        #3_000_000;
        failures++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        void'($urandom(32'h1dc1_63ee));
        repeat (3) @(posedge clk);
        #1;
        chk({rdy, pd, oe}, 3'b110);
        rst = 1'b0;
        push();
        push();
        chk(rdy, 0);
        repeat (3)
        begin
            conv(0);
            host_u.select(0);
            rd(18, 18, cur[17:0]);
        end
        repeat (4)
        begin
            cfg = {3'($urandom), 1'b1, 2'($urandom), 1'b0, 1'($urandom)};
            conv(0);
            host_u.select(0);
            rd(24, 24, {cur[17:0], cur[18], cfg[3:1], 2'b00});
        end
        conv(0);
        host_u.select(0);
        rd(20, 24, {cur[17:0], cur[18], cfg[3:1], 2'b00});
        conv(0);
        host_u.select(0);
        rd(5, 24, {cur[17:0], 6'h00});
        cfg = 8'h00;
        repeat (2)
        begin
            conv(1);
            rd(19, 19, {1'b0, cur[17:0]});
        end
        cfg = {3'($urandom), 1'b0, 3'b001, 1'($urandom)};
        repeat (2)
        begin
            conv(0);
            host_u.select(0);
            rd(18, 18, prev[17:0]);
        end
        conv(0);
        host_u.select(1);
        rd(18, 18, prev[17:0]);
        host_u.serial_in = 1'b1;
        conv(0);
        host_u.select(1);
        rd(5, 18, prev[17:0]);
        host_u.serial_in = 1'b1;
        tick(4);
        chk(oe, 0);
        host_u.convert_start = 1'b0;
        tick(4);
        host_u.serial_in = 1'b0;
        tick(2);
        host_u.convert_start = 1'b1;
        tick(12);
        host_u.convert_start = 1'b0;
        host_u.shift(3, got);
        chk(oe, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
